// ==== inc/wdpr_pkg.sv ====
// constants, register layouts and bus carrier for the watchdog / power / reset block
package wdpr_pkg;

  // ------------------------------------------------------------------
  // clock
  // ------------------------------------------------------------------
  localparam int          CLK_HZ        = 10_000_000;
  localparam int          CLK_PERIOD_NS = 100;
  localparam int          OSC_PER_MC    = 12;
  localparam logic [3:0]  MC_LAST_SLOT  = 4'(OSC_PER_MC - 1);
  localparam logic [3:0]  STATE5_PHASE2_SLOT     = 4'h9;
  localparam logic [3:0]  ALE_SLOT_A0   = 4'h1;
  localparam logic [3:0]  ALE_SLOT_A1   = 4'h2;
  localparam logic [3:0]  ALE_SLOT_B0   = 4'h7;
  localparam logic [3:0]  ALE_SLOT_B1   = 4'h8;

  // ------------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------------
  localparam logic [7:0]  POWER_CONTROL_REG_ADDR     = 8'h87;
  localparam logic [7:0]  AUX_ADDR      = 8'h8e;
  localparam logic [7:0]  WATCHDOG_CONTROL_REG_ADDR     = 8'h8f;

  // ------------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------------
  localparam logic [7:0]  POWER_CONTROL_REG_RESET    = 8'h00;
  localparam logic [7:0]  AUX_RESET     = 8'h00;
  localparam logic [7:0]  WATCHDOG_CONTROL_REG_RESET    = 8'h00;
  localparam logic [7:0]  PORT_RESET    = 8'hff;
  localparam logic [7:0]  SP_RESET      = 8'h07;
  localparam logic [7:0]  READ_IDLE     = 8'h00;

  // ------------------------------------------------------------------
  // counts
  // ------------------------------------------------------------------
  localparam int          WDT_BITS_DEF  = 14;
  localparam logic [1:0]  RST_SAMPLES   = 2'h2;
  localparam logic [1:0]  WD_RST_MC     = 2'h2;

  // ------------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------------
  localparam int          POWER_CONTROL_REG_LOST_POS = 4;
  localparam int          POWER_CONTROL_REG_UF1_POS  = 3;
  localparam int          POWER_CONTROL_REG_UF0_POS  = 2;
  localparam int          POWER_CONTROL_REG_DEEP_POS = 1;
  localparam int          POWER_CONTROL_REG_IDLE_POS = 0;
  localparam int          WATCHDOG_CONTROL_REG_RUN_POS  = 7;
  localparam int          WATCHDOG_CONTROL_REG_CLR_POS  = 6;
  localparam int          WATCHDOG_CONTROL_REG_WATCHDOG_IN_LIGHT_SLEEP_POS = 5;
  localparam int          AUX_AO_POS    = 0;

  // ------------------------------------------------------------------
  // types
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [2:0] rsvd;
    logic       power_lost_flag;
    logic       user_flag_1;
    logic       user_flag_0;
    logic       deep_sleep_bit;
    logic       light_sleep_bit;
  } wdpr_power_control_reg_t;

  typedef struct packed {
    logic       watchdog_run_bit;
    logic       watchdog_restart_bit;
    logic       watchdog_in_light_sleep;
    logic [1:0] rsvd;
    logic [2:0] divider_select;
  } wdpr_watchdog_control_reg_t;

  typedef struct packed {
    logic [6:0] rsvd;
    logic       ale_off_bit;
  } wdpr_aux_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } wdpr_req_t;

endpackage

// ==== core/wdpr_ctrl.sv ====
// watchdog, power control, reset filter and address latch strobe control
// Notes on behaviour
// - ale_off_bit set stops address latch strobe pulses.
// - strobe still pulses during external accesses, stops again after.
// - power_lost_flag set by cold reset, software clears, warm resets keep it.
// - user_flag_1 and user_flag_0 are plain read/write storage.
// - light sleep gates core clock; peripherals keep clocks.
// - enabled interrupt or any reset ends light sleep.
// - deep sleep stops all clocks; only reset wakes.
// - any reset disables watchdog and clears counter and prescaler.
// - watchdog counts only while watchdog_run_bit is set.
// - restart bit clears counter, prescaler and itself next machine cycle.
// - watchdog counts in light sleep only with watchdog_in_light_sleep set.
// - divider_select picks prescale ratio 2 to 256 per table.
// - timeout is 2^14 times ratio times 12 oscillator periods.
// - enabled watchdog timeout causes full system reset.
// - input clock used undivided; each oscillator period is one phase.
// - reset pin sampled at state5_phase2, held two machine cycles; in deep sleep the filtered pin level resets directly.
// - reset pin filtered against short glitches.
// - reset sets registers to reset values; power bit 4 excepted.
//
// Added by the designer: the plain strobed port.
module wdpr_ctrl #(
  parameter int WDT_BITS = wdpr_pkg::WDT_BITS_DEF
) (
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              rstn,
  // register port
  input  wire wdpr_pkg::wdpr_req_t req,
  output logic [7:0]             rdata,
  // pins
  input  wire logic              rst_pin,
  output logic                   ale_out,
  // core side
  input  wire logic              irq_pending,
  input  wire logic              ext_access,
  output logic                   core_clk_en,
  output logic                   periph_clk_en,
  output logic                   osc_run,
  output logic                   sys_reset
);

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  function automatic logic [7:0] ratio_last(input logic [2:0] sel);
    case (sel)
      3'h0:    ratio_last = 8'h01;
      3'h2:    ratio_last = 8'h03;
      3'h1:    ratio_last = 8'h07;
      3'h3:    ratio_last = 8'h0f;
      3'h4:    ratio_last = 8'h1f;
      3'h5:    ratio_last = 8'h3f;
      3'h6:    ratio_last = 8'h7f;
      default: ratio_last = 8'hff;
    endcase
  endfunction

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  wdpr_pkg::wdpr_power_control_reg_t  power_control_reg;
  wdpr_pkg::wdpr_aux_t   aux;
  wdpr_pkg::wdpr_watchdog_control_reg_t  watchdog_control_reg;
  logic [3:0]            slot;
  logic                  pin_s1;
  logic                  pin_s2;
  logic                  pin_s3;
  logic                  pin_lvl;
  logic [1:0]            samp_cnt;
  logic [1:0]            wd_mc;
  logic [7:0]            pre;
  logic [WDT_BITS-1:0]   wd_cnt;

  // ------------------------------------------------------------------
  // decode
  // ------------------------------------------------------------------
  wire       deep      = power_control_reg.deep_sleep_bit;
  wire       light     = power_control_reg.light_sleep_bit;
  wire       mc_end    = (slot == wdpr_pkg::MC_LAST_SLOT) && !deep;
  wire       state5_phase2      = (slot == wdpr_pkg::STATE5_PHASE2_SLOT) && !deep;
  wire       pin_rst   = (samp_cnt == wdpr_pkg::RST_SAMPLES);
  wire       wd_rst    = (wd_mc != 2'h0);
  wire       reg_rst   = !rstn || pin_rst || wd_rst;
  wire       wr_power_control_reg   = req.wr && (req.addr == wdpr_pkg::POWER_CONTROL_REG_ADDR);
  wire       wr_aux    = req.wr && (req.addr == wdpr_pkg::AUX_ADDR);
  wire       wr_watchdog_control_reg   = req.wr && (req.addr == wdpr_pkg::WATCHDOG_CONTROL_REG_ADDR);
  wire       clr_now   = watchdog_control_reg.watchdog_restart_bit && mc_end;
  wire       cnt_en    = watchdog_control_reg.watchdog_run_bit && mc_end
                         && (!light || watchdog_control_reg.watchdog_in_light_sleep);
  wire       pre_last  = (pre == ratio_last(watchdog_control_reg.divider_select));
  wire       timeout   = cnt_en && pre_last && (&wd_cnt);
  wire       ale_slot  = (slot == wdpr_pkg::ALE_SLOT_A0) || (slot == wdpr_pkg::ALE_SLOT_A1)
                         || (slot == wdpr_pkg::ALE_SLOT_B0) || (slot == wdpr_pkg::ALE_SLOT_B1);
  wire       next_ale  = ale_slot && !deep && (!aux.ale_off_bit || ext_access);
  wire [3:0] next_slot = (slot == wdpr_pkg::MC_LAST_SLOT) ? 4'h0 : slot + 4'h1;
  wire [7:0] rd_mux    = (req.addr == wdpr_pkg::POWER_CONTROL_REG_ADDR) ? power_control_reg :
                         (req.addr == wdpr_pkg::AUX_ADDR)  ? aux  :
                         (req.addr == wdpr_pkg::WATCHDOG_CONTROL_REG_ADDR) ? watchdog_control_reg : wdpr_pkg::READ_IDLE;
  wire [7:0] next_rdata = req.rd ? rd_mux : wdpr_pkg::READ_IDLE;

  // ------------------------------------------------------------------
  // phase slots: oscillator split into states of two phases
  // ------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      slot <= 4'h0;
    end else if (!deep) begin
      slot <= next_slot;
    end
  end

  // ------------------------------------------------------------------
  // reset pin: synchroniser, filter, sampling
  // ------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      pin_s1  <= 1'b0;
      pin_s2  <= 1'b0;
      pin_s3  <= 1'b0;
      pin_lvl <= 1'b0;
    end else begin
      pin_s1 <= rst_pin;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      if (pin_s2 == pin_s3) begin
        pin_lvl <= pin_s3;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      samp_cnt <= 2'h0;
    end else if (deep && pin_lvl) begin
      samp_cnt <= wdpr_pkg::RST_SAMPLES;
    end else if (state5_phase2) begin
      if (!pin_lvl) begin
        samp_cnt <= 2'h0;
      end else if (!pin_rst) begin
        samp_cnt <= samp_cnt + 2'h1;
      end
    end
  end

  // watchdog reset stretch
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      wd_mc <= 2'h0;
    end else if (timeout) begin
      wd_mc <= wdpr_pkg::WD_RST_MC;
    end else if (mc_end && wd_rst) begin
      wd_mc <= wd_mc - 2'h1;
    end
  end

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      power_control_reg                 <= wdpr_pkg::POWER_CONTROL_REG_RESET;
      power_control_reg.power_lost_flag <= 1'b1;
    end else if (reg_rst) begin
      power_control_reg.light_sleep_bit <= 1'b0;
      power_control_reg.deep_sleep_bit  <= 1'b0;
      power_control_reg.user_flag_0     <= 1'b0;
      power_control_reg.user_flag_1     <= 1'b0;
    end else begin
      if (wr_power_control_reg) begin
        power_control_reg.power_lost_flag <= req.wdata[wdpr_pkg::POWER_CONTROL_REG_LOST_POS];
        power_control_reg.user_flag_1     <= req.wdata[wdpr_pkg::POWER_CONTROL_REG_UF1_POS];
        power_control_reg.user_flag_0     <= req.wdata[wdpr_pkg::POWER_CONTROL_REG_UF0_POS];
        power_control_reg.deep_sleep_bit  <= req.wdata[wdpr_pkg::POWER_CONTROL_REG_DEEP_POS];
      end
      if (irq_pending) begin
        power_control_reg.light_sleep_bit <= 1'b0;
      end else if (wr_power_control_reg) begin
        power_control_reg.light_sleep_bit <= req.wdata[wdpr_pkg::POWER_CONTROL_REG_IDLE_POS];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reg_rst) begin
      aux <= wdpr_pkg::AUX_RESET;
    end else if (wr_aux) begin
      aux.ale_off_bit <= req.wdata[wdpr_pkg::AUX_AO_POS];
    end
  end

  always_ff @(posedge mclk) begin
    if (reg_rst) begin
      watchdog_control_reg <= wdpr_pkg::WATCHDOG_CONTROL_REG_RESET;
    end else begin
      if (wr_watchdog_control_reg) begin
        watchdog_control_reg.watchdog_run_bit        <= req.wdata[wdpr_pkg::WATCHDOG_CONTROL_REG_RUN_POS];
        watchdog_control_reg.watchdog_in_light_sleep <= req.wdata[wdpr_pkg::WATCHDOG_CONTROL_REG_WATCHDOG_IN_LIGHT_SLEEP_POS];
        watchdog_control_reg.divider_select          <= req.wdata[2:0];
      end
      if (wr_watchdog_control_reg && req.wdata[wdpr_pkg::WATCHDOG_CONTROL_REG_CLR_POS]) begin
        watchdog_control_reg.watchdog_restart_bit <= 1'b1;
      end else if (mc_end) begin
        watchdog_control_reg.watchdog_restart_bit <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // watchdog prescaler and counter
  // ------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reg_rst || clr_now) begin
      pre    <= 8'h00;
      wd_cnt <= '0;
    end else if (cnt_en) begin
      pre <= pre_last ? 8'h00 : pre + 8'h01;
      if (pre_last) begin
        wd_cnt <= wd_cnt + 1'b1;
      end
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      rdata         <= wdpr_pkg::READ_IDLE;
      ale_out       <= 1'b0;
      core_clk_en   <= 1'b1;
      periph_clk_en <= 1'b1;
      osc_run       <= 1'b1;
      sys_reset     <= 1'b1;
    end else begin
      rdata         <= next_rdata;
      ale_out       <= next_ale;
      core_clk_en   <= !(light || deep);
      periph_clk_en <= !deep;
      osc_run       <= !deep;
      sys_reset     <= reg_rst;
    end
  end

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);

  a_ale_off_quiet: assert property (aux.ale_off_bit && !ext_access && !wr_aux |=> !ale_out)
    else $error("strobe pulsed while turned off");
  a_ale_ext_drive: assert property (ext_access && !deep && slot == 4'h1 |=> ale_out)
    else $error("strobe missing during external access");
  a_lost_cold: assert property (disable iff (1'b0) !rstn |=> power_control_reg.power_lost_flag)
    else $error("power lost flag not set by cold reset");
  a_lost_warm: assert property (reg_rst && !wr_power_control_reg |=> $stable(power_control_reg.power_lost_flag))
    else $error("warm reset changed power lost flag");
  a_user_flags: assert property (wr_power_control_reg && !reg_rst
                                 |=> power_control_reg.user_flag_1 == $past(req.wdata[3])
                                     && power_control_reg.user_flag_0 == $past(req.wdata[2]))
    else $error("user flags not stored");
  a_idle_gate: assert property (light && !deep |=> !core_clk_en && periph_clk_en)
    else $error("light sleep clock gating wrong");
  a_idle_exit: assert property (light && irq_pending |=> !power_control_reg.light_sleep_bit)
    else $error("light sleep not left on interrupt");
  a_deep_stop: assert property (deep && !reg_rst |=> !osc_run && !periph_clk_en
                                && $stable(wd_cnt) && $stable(slot))
    else $error("deep sleep left clocks or watchdog running");
  a_reset_wdog: assert property (reg_rst |=> !watchdog_control_reg.watchdog_run_bit && wd_cnt == '0
                                 && pre == 8'h00)
    else $error("reset left watchdog active");
  a_wdog_idle: assert property (!watchdog_control_reg.watchdog_run_bit && !reg_rst && !clr_now
                                |=> $stable(wd_cnt) && $stable(pre))
    else $error("disabled watchdog counted");
  a_restart_clear: assert property (clr_now && !reg_rst && !wr_watchdog_control_reg
                                    |=> wd_cnt == '0 && pre == 8'h00
                                        && !watchdog_control_reg.watchdog_restart_bit)
    else $error("restart did not clear watchdog");
  a_light_pause: assert property (light && !watchdog_control_reg.watchdog_in_light_sleep && !reg_rst
                                  && !clr_now |=> $stable(pre))
    else $error("watchdog counted in light sleep");
  a_pre_wrap: assert property (cnt_en && pre_last && !clr_now && !reg_rst
                               |=> pre == 8'h00)
    else $error("prescaler wrap wrong");
  a_timeout_rst: assert property (timeout |=> wd_mc == 2'h2 ##1 sys_reset)
    else $error("timeout did not reset system");
  a_pin_sample: assert property (!state5_phase2 && !deep |=> $stable(samp_cnt))
    else $error("reset pin sampled outside its slot");

endmodule // wdpr_ctrl

// ==== verif/wdpr_tb.sv ====
// self-checking bench for the watchdog / power / reset block
module testbench;
  timeunit 1ns;
  timeprecision 1ns;

  // ------------------------------------------------------------------
  // signals
  // ------------------------------------------------------------------
  logic                mclk          = 1'b0;
  logic                rstn          = 1'b0;
  wdpr_pkg::wdpr_req_t req           = '0;
  logic                rst_pin       = 1'b0;
  logic                irq_pending   = 1'b0;
  logic                ext_access    = 1'b0;
  logic [7:0]          rdata;
  logic                ale_out;
  logic                core_clk_en;
  logic                periph_clk_en;
  logic                osc_run;
  logic                sys_reset;
  int                  err_count     = 0;
  int                  num_checks    = 0;
  int                  cyc           = 0;
  logic                saw_rst       = 1'b0;
  int                  ratio [8]     = '{2, 8, 4, 16, 32, 64, 128, 256};
  int                  n;
  int                  hi;

  always #50 mclk = ~mclk;

  // short watchdog: timeout after 4 * ratio machine cycles
  wdpr_ctrl #(.WDT_BITS(2)) uut (
    .mclk(mclk), .rstn(rstn), .req(req), .rdata(rdata), .rst_pin(rst_pin),
    .ale_out(ale_out), .irq_pending(irq_pending), .ext_access(ext_access),
    .core_clk_en(core_clk_en), .periph_clk_en(periph_clk_en),
    .osc_run(osc_run), .sys_reset(sys_reset));

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  always @(posedge mclk) begin
    cyc++;
    if (sys_reset === 1'b1) saw_rst = 1'b1;
    if (cyc == 60000) begin
      err_count++;
      $display("MISMATCH t=%0t run limit reached", $time);
      test_done();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    req.addr  <= a;
    req.wdata <= d;
    req.wr    <= 1'b1;
    @(posedge mclk);
    req.wr    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    req.addr <= a;
    req.rd   <= 1'b1;
    @(posedge mclk);
    req.rd   <= 1'b0;
    #1;
    chk(rdata, e);
  endtask

  task automatic wait_rel();
    int k;
    k = 0;
    @(posedge mclk);
    #1;
    while (sys_reset !== 1'b0 && k < 200) begin
      @(posedge mclk);
      #1;
      k++;
    end
    chk({7'h0, sys_reset}, 8'h00);
  endtask

  task automatic pin_reset(input int len);
    @(posedge mclk);
    rst_pin <= 1'b1;
    repeat (len) @(posedge mclk);
    rst_pin <= 1'b0;
  endtask

  task automatic ale_cnt(output int c);
    c = 0;
    repeat (24) begin
      @(posedge mclk);
      #1;
      if (ale_out === 1'b1) c++;
    end
  endtask

  // ------------------------------------------------------------------
  // tests
  // ------------------------------------------------------------------
  initial begin
    repeat (5) @(posedge mclk);
    rstn <= 1'b1;
    wait_rel();
    rd(wdpr_pkg::POWER_CONTROL_REG_ADDR, 8'h10);
    rd(wdpr_pkg::AUX_ADDR, 8'h00);
    rd(wdpr_pkg::WATCHDOG_CONTROL_REG_ADDR, 8'h00);
    rd(8'h90, 8'h00);
    wr(wdpr_pkg::POWER_CONTROL_REG_ADDR, 8'h1c);
    rd(wdpr_pkg::POWER_CONTROL_REG_ADDR, 8'h1c);
    wr(wdpr_pkg::POWER_CONTROL_REG_ADDR, 8'h0c);
    rd(wdpr_pkg::POWER_CONTROL_REG_ADDR, 8'h0c);
    // glitch shorter than one machine cycle
    saw_rst = 1'b0;
    pin_reset(3);
    repeat (40) @(posedge mclk);
    chk({7'h0, saw_rst}, 8'h00);
    pin_reset(40);
    wait_rel();
    chk({7'h0, saw_rst}, 8'h01);
    rd(wdpr_pkg::POWER_CONTROL_REG_ADDR, 8'h00);
    // watchdog left off never fires
    saw_rst = 1'b0;
    repeat (300) @(posedge mclk);
    chk({7'h0, saw_rst}, 8'h00);
    // address latch strobe
    ale_cnt(n);
    chk(8'(n), 8'h08);
    wr(wdpr_pkg::AUX_ADDR, 8'h01);
    ale_cnt(n);
    chk(8'(n), 8'h00);
    @(posedge mclk);
    ext_access <= 1'b1;
    ale_cnt(n);
    chk(8'(n), 8'h08);
    @(posedge mclk);
    ext_access <= 1'b0;
    ale_cnt(n);
    chk(8'(n), 8'h00);
    wr(wdpr_pkg::AUX_ADDR, 8'h00);
    // light sleep pauses the watchdog when in_light is clear
    wr(wdpr_pkg::WATCHDOG_CONTROL_REG_ADDR, 8'h80);
    wr(wdpr_pkg::POWER_CONTROL_REG_ADDR, 8'h01);
    repeat (3) @(posedge mclk);
    #1;
    chk({6'h0, core_clk_en, periph_clk_en}, 8'h01);
    repeat (300) @(posedge mclk);
    chk({7'h0, saw_rst}, 8'h00);
    @(posedge mclk);
    irq_pending <= 1'b1;
    @(posedge mclk);
    irq_pending <= 1'b0;
    repeat (3) @(posedge mclk);
    #1;
    chk({7'h0, core_clk_en}, 8'h01);
    // light sleep with in_light set keeps the watchdog counting
    wr(wdpr_pkg::POWER_CONTROL_REG_ADDR, 8'h01);
    wr(wdpr_pkg::WATCHDOG_CONTROL_REG_ADDR, 8'he0);
    saw_rst = 1'b0;
    repeat (200) @(posedge mclk);
    chk({7'h0, saw_rst}, 8'h01);
    wr(wdpr_pkg::WATCHDOG_CONTROL_REG_ADDR, 8'h00);
    // restarts faster than the timeout keep it quiet
    pin_reset(40);
    wait_rel();
    saw_rst = 1'b0;
    wr(wdpr_pkg::WATCHDOG_CONTROL_REG_ADDR, 8'h80);
    repeat (10) begin
      repeat (48) @(posedge mclk);
      wr(wdpr_pkg::WATCHDOG_CONTROL_REG_ADDR, 8'hc0);
    end
    chk({7'h0, saw_rst}, 8'h00);
    repeat (12) @(posedge mclk);
    rd(wdpr_pkg::WATCHDOG_CONTROL_REG_ADDR, 8'h80);
    wr(wdpr_pkg::WATCHDOG_CONTROL_REG_ADDR, 8'h00);
    pin_reset(40);
    wait_rel();
    // every prescale ratio: timeout, stretch, cleared state
    for (int s = 0; s < 8; s++) begin
      wr(wdpr_pkg::WATCHDOG_CONTROL_REG_ADDR, 8'h80 | 8'(s));
      n = 0;
      while (sys_reset !== 1'b1 && n < 48 * ratio[s] + 60) begin
        @(posedge mclk);
        #1;
        n++;
      end
      chk({7'h0, 1'(n >= 48 * ratio[s] - 14 && n <= 48 * ratio[s] + 14)}, 8'h01);
      hi = 0;
      while (sys_reset === 1'b1 && hi < 200) begin
        @(posedge mclk);
        #1;
        hi++;
      end
      chk({7'h0, 1'(hi >= 24)}, 8'h01);
      rd(wdpr_pkg::WATCHDOG_CONTROL_REG_ADDR, 8'h00);
    end
    // deep sleep stops everything until a reset
    wr(wdpr_pkg::POWER_CONTROL_REG_ADDR, 8'h02);
    repeat (3) @(posedge mclk);
    #1;
    chk({5'h0, osc_run, periph_clk_en, core_clk_en}, 8'h00);
    ale_cnt(n);
    chk(8'(n), 8'h00);
    pin_reset(40);
    wait_rel();
    chk({5'h0, osc_run, periph_clk_en, core_clk_en}, 8'h07);
    test_done();
  end
endmodule // testbench
